// file: verilog/rdc_pkg.sv
package rdc_pkg;

    // register byte addresses
    localparam logic [7:0] RDC_ADDR_TRANSLATOR = 8'h0a;
    localparam logic [7:0] RDC_ADDR_PRESET = 8'h0c;
    localparam logic [7:0] RDC_ADDR_CEIL1 = 8'h0d;
    localparam logic [7:0] RDC_ADDR_CEIL2 = 8'h0e;
    localparam logic [7:0] RDC_ADDR_CEIL3 = 8'h0f;
    localparam logic [7:0] RDC_ADDR_CTRL1 = 8'h10;

    // field positions
    localparam int RDC_TRANSLATOR_LSB = 0;
    localparam int RDC_TRANSLATOR_W = 2;
    localparam int RDC_CEIL_W = 7;
    localparam int RDC_NUM_REG = 3;

    // reset values
    localparam logic [1:0] RDC_TRANSLATOR_RST = 2'h0;
    localparam logic [7:0] RDC_PRESET_RST = 8'ha9;
    localparam logic [6:0] RDC_CEIL1_RST = 7'h1c;
    localparam logic [6:0] RDC_CEIL2_RST = 7'h20;
    localparam logic [6:0] RDC_CEIL3_RST = 7'h1c;
    localparam logic [7:0] RDC_CTRL1_RST = 8'h49;

    // voltage codes: 0.60 V plus 12.5 mV per step
    localparam logic [6:0] RDC_CODE_0V80 = 7'h10;
    localparam logic [6:0] RDC_CODE_1V00 = 7'h20;
    localparam logic [6:0] RDC_CODE_STEP50 = 7'h04;
    localparam logic [7:0] RDC_READ_ZERO = 8'h00;

    typedef enum logic [1:0] {
        RDC_LT_OFF = 2'h0,
        RDC_LT_STANDBY = 2'h1,
        RDC_LT_RUN = 2'h2,
        RDC_LT_ON = 2'h3
    } rdc_lt_mode_t;

    typedef enum logic [1:0] {
        RDC_EN_OFF = 2'h0,
        RDC_EN_ON_REQ = 2'h1,
        RDC_EN_ON_RUN = 2'h2,
        RDC_EN_ALWAYS = 2'h3
    } rdc_en_mode_t;

    typedef struct packed {
        logic preset_en;
        logic [1:0] reg3_preset_code;
        logic [1:0] reg1_preset_code;
        logic [2:0] reg2_preset_code;
    } rdc_preset_t;

    typedef struct packed {
        logic [1:0] ramp;
        logic rsvd;
        logic scaling_source_ctrl;
        logic reg1_discharge_en;
        logic forced_pulse_width_sel;
        logic [1:0] reg1_enable_mode;
    } rdc_ctrl_t;

endpackage

// file: verilog/rdc_regs.sv
`timescale 1ns/10ps

module rdc_regs
    import rdc_pkg::*;
#(
    parameter logic HAS_REG3 = 1'b1
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic POWER_ON_REQUEST,
    input wire logic STANDBY_REQUEST,
    input wire logic [6:0] REG1_VOLTAGE_SEL0,
    input wire logic [6:0] REG1_VOLTAGE_SEL1,
    input wire logic [6:0] REG2_VOLTAGE_SEL,
    input wire logic [6:0] REG3_VOLTAGE_SEL,
    output logic TRANSLATOR_EN,
    output logic REG1_ENABLE,
    output logic REG1_DISCHARGE,
    output logic REG1_FORCED_PWM,
    output logic [1:0] REG1_RAMP,
    output logic [6:0] REG1_TARGET,
    output logic [6:0] REG2_TARGET,
    output logic [6:0] REG3_TARGET
);

    function automatic logic [6:0] preset_two_bit(input logic [1:0] code);
        // 0.80, 0.85, 0.90, 0.95 V in 50 mV steps
        preset_two_bit = RDC_CODE_0V80 + 7'({5'h00, code} * RDC_CODE_STEP50);
    endfunction

    function automatic logic [6:0] clamp_code(input logic [6:0] code, input logic [6:0] ceil);
        clamp_code = (code > ceil) ? ceil : code;
    endfunction

    logic [1:0] translator_enable_sel;
    logic [1:0] next_translator_enable_sel;
    rdc_preset_t preset;
    rdc_preset_t next_preset;
    logic [6:0] reg1_ceiling_code;
    logic [6:0] next_reg1_ceiling_code;
    logic [6:0] reg2_ceiling_code;
    logic [6:0] next_reg2_ceiling_code;
    logic [6:0] reg3_ceiling_code;
    logic [6:0] next_reg3_ceiling_code;
    rdc_ctrl_t ctrl1;
    rdc_ctrl_t next_ctrl1;
    logic [7:0] next_rdata;

    // register write and read
    always_comb
    begin
        next_translator_enable_sel = translator_enable_sel;
        next_preset = preset;
        next_reg1_ceiling_code = reg1_ceiling_code;
        next_reg2_ceiling_code = reg2_ceiling_code;
        next_reg3_ceiling_code = reg3_ceiling_code;
        next_ctrl1 = ctrl1;
        next_rdata = REG_RDATA;
        if (REG_WR)
        begin
            case (REG_ADDR)
                RDC_ADDR_TRANSLATOR:
                begin
                    next_translator_enable_sel =
                        REG_WDATA[RDC_TRANSLATOR_LSB +: RDC_TRANSLATOR_W];
                end
                RDC_ADDR_PRESET:
                begin
                    next_preset = rdc_preset_t'(REG_WDATA);
                end
                RDC_ADDR_CEIL1:
                begin
                    next_reg1_ceiling_code = REG_WDATA[RDC_CEIL_W-1:0];
                end
                RDC_ADDR_CEIL2:
                begin
                    next_reg2_ceiling_code = REG_WDATA[RDC_CEIL_W-1:0];
                end
                RDC_ADDR_CEIL3:
                begin
                    next_reg3_ceiling_code = REG_WDATA[RDC_CEIL_W-1:0];
                end
                RDC_ADDR_CTRL1:
                begin
                    next_ctrl1 = rdc_ctrl_t'(REG_WDATA);
                    next_ctrl1.rsvd = 1'b0;
                end
                default:
                begin
                    // unmapped address: the write is dropped
                    next_ctrl1 = ctrl1;
                end
            endcase
        end
        if (REG_RD)
        begin
            case (REG_ADDR)
                RDC_ADDR_TRANSLATOR:
                begin
                    next_rdata = {6'h00, translator_enable_sel};
                end
                RDC_ADDR_PRESET:
                begin
                    next_rdata = preset;
                end
                RDC_ADDR_CEIL1:
                begin
                    next_rdata = {1'b0, reg1_ceiling_code};
                end
                RDC_ADDR_CEIL2:
                begin
                    next_rdata = {1'b0, reg2_ceiling_code};
                end
                RDC_ADDR_CEIL3:
                begin
                    next_rdata = {1'b0, reg3_ceiling_code};
                end
                RDC_ADDR_CTRL1:
                begin
                    next_rdata = ctrl1;
                end
                default:
                begin
                    next_rdata = RDC_READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            translator_enable_sel <= RDC_TRANSLATOR_RST;
            preset <= rdc_preset_t'(RDC_PRESET_RST);
            reg1_ceiling_code <= RDC_CEIL1_RST;
            reg2_ceiling_code <= RDC_CEIL2_RST;
            reg3_ceiling_code <= RDC_CEIL3_RST;
            ctrl1 <= rdc_ctrl_t'(RDC_CTRL1_RST);
            REG_RDATA <= RDC_READ_ZERO;
        end
        else if (CE)
        begin
            translator_enable_sel <= next_translator_enable_sel;
            preset <= next_preset;
            reg1_ceiling_code <= next_reg1_ceiling_code;
            reg2_ceiling_code <= next_reg2_ceiling_code;
            reg3_ceiling_code <= next_reg3_ceiling_code;
            ctrl1 <= next_ctrl1;
            REG_RDATA <= next_rdata;
        end
    end

    // source selection and ceiling clamp
    logic [6:0] sel_code [RDC_NUM_REG];
    logic [6:0] ceil_code [RDC_NUM_REG];
    logic [6:0] next_target [RDC_NUM_REG];
    logic [6:0] reg1_own_sel;

    always_comb
    begin
        reg1_own_sel = REG1_VOLTAGE_SEL0;
        if (ctrl1.scaling_source_ctrl && STANDBY_REQUEST)
        begin
            reg1_own_sel = REG1_VOLTAGE_SEL1;
        end
        sel_code[0] = reg1_own_sel;
        sel_code[1] = REG2_VOLTAGE_SEL;
        sel_code[2] = REG3_VOLTAGE_SEL;
        if (preset.preset_en)
        begin
            sel_code[0] = preset_two_bit(preset.reg1_preset_code);
            sel_code[1] = preset.reg2_preset_code[2] ? RDC_CODE_1V00 :
                preset_two_bit(preset.reg2_preset_code[1:0]);
            sel_code[2] = preset_two_bit(preset.reg3_preset_code);
        end
        ceil_code[0] = reg1_ceiling_code;
        ceil_code[1] = reg2_ceiling_code;
        ceil_code[2] = reg3_ceiling_code;
    end

    genvar gi;
    generate
        for (gi = 0; gi < RDC_NUM_REG; gi++)
        begin : g_clamp
            assign next_target[gi] = clamp_code(sel_code[gi], ceil_code[gi]);
        end
    endgenerate

    // pin-driven control decode
    logic next_translator_en;
    logic next_reg1_enable;

    always_comb
    begin
        case (rdc_lt_mode_t'(translator_enable_sel))
            RDC_LT_OFF: next_translator_en = 1'b0;
            RDC_LT_STANDBY: next_translator_en = STANDBY_REQUEST;
            RDC_LT_RUN: next_translator_en = !STANDBY_REQUEST;
            RDC_LT_ON: next_translator_en = 1'b1;
            default: next_translator_en = 1'b0;
        endcase
        case (rdc_en_mode_t'(ctrl1.reg1_enable_mode))
            RDC_EN_OFF: next_reg1_enable = 1'b0;
            RDC_EN_ON_REQ: next_reg1_enable = POWER_ON_REQUEST;
            RDC_EN_ON_RUN: next_reg1_enable = POWER_ON_REQUEST && !STANDBY_REQUEST;
            RDC_EN_ALWAYS: next_reg1_enable = 1'b1;
            default: next_reg1_enable = 1'b0;
        endcase
    end

    // outputs registered one cycle after their causes
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            TRANSLATOR_EN <= 1'b0;
            REG1_ENABLE <= 1'b0;
            REG1_DISCHARGE <= 1'b0;
            REG1_FORCED_PWM <= 1'b0;
            REG1_RAMP <= 2'h0;
            REG1_TARGET <= 7'h00;
            REG2_TARGET <= 7'h00;
            REG3_TARGET <= 7'h00;
        end
        else if (CE)
        begin
            TRANSLATOR_EN <= next_translator_en;
            REG1_ENABLE <= next_reg1_enable;
            // discharge follows the enable decision of the same cycle, so no overlap
            REG1_DISCHARGE <= ctrl1.reg1_discharge_en && !next_reg1_enable;
            REG1_FORCED_PWM <= ctrl1.forced_pulse_width_sel;
            REG1_RAMP <= ctrl1.ramp;
            REG1_TARGET <= next_target[0];
            REG2_TARGET <= next_target[1];
            // variant without the third regulator keeps its target at zero
            REG3_TARGET <= HAS_REG3 ? next_target[2] : 7'h00;
        end
    end

endmodule

// file: verification/rdc_regs_props.sv
`timescale 1ns/10ps
module rdc_regs_props (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic POWER_ON_REQUEST,
    input wire logic STANDBY_REQUEST,
    input wire logic TRANSLATOR_EN,
    input wire logic REG1_ENABLE,
    input wire logic REG1_DISCHARGE,
    input wire logic REG1_FORCED_PWM,
    input wire logic [1:0] REG1_RAMP
);
    logic [7:0] ctl, next_ctl;
    logic [1:0] lt, next_lt;
    logic en, ten, dis;
    logic [2:0] pr;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // shadow copies from the write port, so decode checks need no hierarchy
    always_comb
    begin
        next_ctl = ctl;
        next_lt = lt;
        if (RESET)
        begin
            next_ctl = 8'h49;
            next_lt = 2'h0;
        end
        else if (CE && REG_WR && REG_ADDR == 8'h10)
            next_ctl = REG_WDATA & 8'hdf;
        else if (CE && REG_WR && REG_ADDR == 8'h0a)
            next_lt = REG_WDATA[1:0];
    end
    always_ff @(posedge CLK)
    begin
        ctl <= next_ctl;
        lt <= next_lt;
    end
    assign en = ctl[1] ? ctl[0] || (POWER_ON_REQUEST && !STANDBY_REQUEST)
        : ctl[0] && POWER_ON_REQUEST;
    assign ten = lt[1] ? lt[0] || !STANDBY_REQUEST : lt[0] && STANDBY_REQUEST;
    assign dis = ctl[3] && !en;
    assign pr = {ctl[2], ctl[7:6]};
    rdata_hold_a: assert property (CE && !REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    ceil_rsvd_a: assert property (CE && REG_RD && REG_ADDR inside {8'h0d, 8'h0e, 8'h0f}
        |=> !REG_RDATA[7]) else $error("ceiling bit 7 not zero");
    ctrl_read_a: assert property (CE && REG_RD && REG_ADDR == 8'h10
        |=> REG_RDATA == $past(ctl)) else $error("control readback wrong");
    lt_read_a: assert property (CE && REG_RD && REG_ADDR == 8'h0a
        |=> REG_RDATA == {6'h00, $past(lt)}) else $error("translator readback wrong");
    translator_en_a: assert property (CE |=> TRANSLATOR_EN == $past(ten))
        else $error("translator enable wrong");
    reg1_enable_a: assert property (CE |=> REG1_ENABLE == $past(en))
        else $error("enable wrong");
    discharge_a: assert property (CE |=> REG1_DISCHARGE == $past(dis))
        else $error("discharge wrong");
    pwm_ramp_a: assert property (CE |=> {REG1_FORCED_PWM, REG1_RAMP} == $past(pr))
        else $error("pwm or ramp wrong");
endmodule

// file: verification/rdc_host.sv
`timescale 1ns/10ps
module rdc_host (
    input wire logic CLK,
    output logic [7:0] REG_ADDR = 8'h00,
    output logic [7:0] REG_WDATA = 8'h00,
    output logic REG_WR = 1'b0,
    output logic REG_RD = 1'b0,
    output logic POWER_ON_REQUEST = 1'b0,
    output logic STANDBY_REQUEST = 1'b0
);
    // one byte per strobe; a released bus shows the inverse, never the old value
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        #1;
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = wr;
        REG_RD = !wr;
        @(posedge CLK);
        #1;
        {REG_WR, REG_RD} = 2'h0;
        REG_ADDR = ~a;
        REG_WDATA = ~d;
    endtask
endmodule

// file: verification/rdc_regs_bench.sv
`timescale 1ns/10ps
module rdc_regs_bench;
    logic CLK = 1'b0;
    logic RESET;
    logic CE = 1'b1;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
    logic REG_WR, REG_RD, POWER_ON_REQUEST, STANDBY_REQUEST;
    logic [6:0] REG1_VOLTAGE_SEL0 = 7'h00, REG1_VOLTAGE_SEL1 = 7'h00;
    logic [6:0] REG2_VOLTAGE_SEL = 7'h00, REG3_VOLTAGE_SEL = 7'h00;
    logic [6:0] REG1_TARGET, REG2_TARGET, REG3_TARGET;
    logic TRANSLATOR_EN, REG1_ENABLE, REG1_DISCHARGE, REG1_FORCED_PWM;
    logic [1:0] REG1_RAMP;
    logic [7:0] r[7];
    logic [7:0] rv[7] = '{8'h00, 8'h00, 8'ha9, 8'h1c, 8'h20, 8'h1c, 8'h49};
    logic [7:0] m[7] = '{8'h03, 8'h00, 8'hff, 8'h7f, 8'h7f, 8'h7f, 8'hdf};
    logic [26:0] q[$];
    logic rd_q = 1'b0;
    logic smp = 1'b0;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    wire [26:0] outv = {TRANSLATOR_EN, REG1_ENABLE, REG1_DISCHARGE, REG1_FORCED_PWM,
        REG1_RAMP, REG1_TARGET, REG2_TARGET, REG3_TARGET};
    rdc_regs u_rdc_regs (.*);
    rdc_host u_host (.*);
    always #20 CLK = ~CLK;
    task automatic check(input string nm, input logic [26:0] seen, input logic [26:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [6:0] lim(input logic [6:0] v, input logic [6:0] c);
        return v > c ? c : v;
    endfunction
    function automatic logic [26:0] ref_out();
        logic [7:0] p, c;
        logic on, sb, en;
        logic [6:0] a, b, d;
        p = r[2];
        c = r[6];
        on = POWER_ON_REQUEST;
        sb = STANDBY_REQUEST;
        en = c[1] ? c[0] || (on && !sb) : c[0] && on;
        a = c[4] && sb ? REG1_VOLTAGE_SEL1 : REG1_VOLTAGE_SEL0;
        a = p[7] ? 7'h10 + {3'h0, p[4:3], 2'h0} : a;
        b = p[2] ? 7'h20 : 7'h10 + {3'h0, p[1:0], 2'h0};
        b = p[7] ? b : REG2_VOLTAGE_SEL;
        d = p[7] ? 7'h10 + {3'h0, p[6:5], 2'h0} : REG3_VOLTAGE_SEL;
        return {r[0][1] ? r[0][0] || !sb : r[0][0] && sb, en, c[3] && !en, c[2], c[7:6],
            lim(a, r[3][6:0]), lim(b, r[4][6:0]), lim(d, r[5][6:0])};
    endfunction
    task automatic rst_chk();
        RESET = 1'b1;
        repeat (16) @(posedge CLK);
        #1;
        RESET = 1'b0;
        r = rv;
        for (int k = 0; k < 7; k++)
        begin
            q.push_back({19'h0, r[k]});
            u_host.xfer(1'b0, 8'h0a + 8'(k), 8'h00);
        end
    endtask
    always @(posedge CLK)
    begin
        if (rd_q)
            check("read data", {19'h0, REG_RDATA}, q.pop_front());
        if (smp)
            check("outputs", outv, q.pop_front());
        rd_q = REG_RD;
        cyc++;
        if (cyc > 6000)
        begin
            n_fail++;
            end_sim();
        end
    end
    initial
    begin
        logic [7:0] d;
        int k;
        void'($urandom(32'hb647));
        rst_chk();
        for (int i = 0; i < 300; i++)
        begin
            k = $urandom_range(6);
            d = 8'($urandom);
            u_host.xfer(1'b1, 8'h0a + 8'(k), d);
            r[k] = d & m[k];
            q.push_back({19'h0, r[k]});
            u_host.xfer(1'b0, 8'h0a + 8'(k), 8'h00);
            {REG1_VOLTAGE_SEL0, REG1_VOLTAGE_SEL1, REG2_VOLTAGE_SEL} = 21'($urandom);
            REG3_VOLTAGE_SEL = 7'($urandom);
            {u_host.POWER_ON_REQUEST, u_host.STANDBY_REQUEST} = 2'($urandom);
            repeat (3) @(posedge CLK);
            #1;
            q.push_back(ref_out());
            smp = 1'b1;
            @(posedge CLK);
            #1;
            smp = 1'b0;
        end
        // a second reset after the random writes, just before the run ends, must bring every register back
        rst_chk();
        repeat (2) @(posedge CLK);
        end_sim();
    end
endmodule
bind rdc_regs rdc_regs_props u_props (.CLK, .RESET, .CE, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .POWER_ON_REQUEST, .STANDBY_REQUEST, .TRANSLATOR_EN,
    .REG1_ENABLE, .REG1_DISCHARGE, .REG1_FORCED_PWM, .REG1_RAMP);
